// *** rtl/wpt_pkg.sv ***
// Package for the data and resource watchpoint block: map, fields and carriers
package wpt_pkg;
  // Counts
  localparam int WPT_NUM = 4;
  localparam int WPT_CORES = 8;
  localparam int WPT_CORE_W = 3;
  localparam int WPT_ADR_W = 10;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DW_FIRST = 8'h50;
  localparam logic [7:0] IDX_DW_SECOND = 8'h60;
  localparam logic [7:0] IDX_DW_CTL = 8'h70;
  localparam logic [7:0] IDX_RW_MASK = 8'h80;
  localparam logic [7:0] IDX_RW_CMP = 8'h90;
  localparam logic [7:0] IDX_RW_CTL = 8'h9C;
  localparam logic [7:0] IDX_CAUSE = 8'h15;
  localparam logic [7:0] IDX_CAPTURE = 8'h16;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hA0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hA1;
  // Control fields
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_INV_BIT = 1;
  localparam int CTL_LOAD_BIT = 2;
  localparam int CTL_CORE_LSB = 16;
  localparam logic [31:0] DW_CTL_WMASK = 32'h00FF0007;
  localparam logic [31:0] RW_CTL_WMASK = 32'h00FF0003;
  localparam logic [31:0] CTL_RESET = 32'h00000000;
  // Cause register fields
  localparam int CAUSE_NUM_LSB = 16;
  localparam int CAUSE_CORE_LSB = 8;
  localparam logic [2:0] CAUSE_DATA = 3'h4;
  localparam logic [2:0] CAUSE_RES = 3'h5;
  // Interrupt status bits
  localparam int IRQ_DATA_BIT = 0;
  localparam int IRQ_RES_BIT = 1;
  localparam int IRQ_W = 2;

  // Memory access from the load/store pipeline
  typedef struct packed {
    logic valid;
    logic store;
    logic [WPT_CORE_W-1:0] core;
    logic [31:0] addr;
  } wpt_mem_acc_t;

  // Resource access from the resource pipeline
  typedef struct packed {
    logic valid;
    logic [WPT_CORE_W-1:0] core;
    logic [31:0] id;
  } wpt_res_acc_t;

  // Whole state of the top module
  typedef struct packed {
    logic [WPT_NUM-1:0][31:0] dw_first;
    logic [WPT_NUM-1:0][31:0] dw_second;
    logic [WPT_NUM-1:0][31:0] dw_ctl;
    logic [WPT_NUM-1:0][31:0] rw_mask;
    logic [WPT_NUM-1:0][31:0] rw_cmp;
    logic [WPT_NUM-1:0][31:0] rw_ctl;
    logic [31:0] cause;
    logic [31:0] capture;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic ack;
    logic [31:0] rdat;
    logic [WPT_NUM-1:0] dw_hit;
    logic [WPT_NUM-1:0] rw_hit;
  } wpt_state_t;
endpackage : wpt_pkg

// *** rtl/wpt_data_cmp.sv ***
// One data watchpoint comparator
`timescale 1ns/1ns
module wpt_data_cmp
  import wpt_pkg::*;
(
  input wire logic [31:0] ctl_i,
  input wire logic [31:0] first_i,
  input wire logic [31:0] second_i,
  input wire wpt_mem_acc_t acc_i,
  output logic hit_o
);
  logic in_range;
  logic range_ok;
  logic kind_ok;
  logic core_ok;

  // Range test on unsigned values
  // unsigned same-cycle compare
  assign in_range = (acc_i.addr >= first_i) && (acc_i.addr <= second_i);
  assign range_ok = ctl_i[CTL_INV_BIT] ? !in_range : in_range;
  assign kind_ok = acc_i.store || ctl_i[CTL_LOAD_BIT];
  assign core_ok = ctl_i[CTL_CORE_LSB + 32'(acc_i.core)];
  assign hit_o = acc_i.valid && ctl_i[CTL_EN_BIT] && kind_ok && core_ok && range_ok;
endmodule : wpt_data_cmp

// *** rtl/wpt_res_cmp.sv ***
// One resource watchpoint comparator
`timescale 1ns/1ns
module wpt_res_cmp
  import wpt_pkg::*;
(
  input wire logic [31:0] ctl_i,
  input wire logic [31:0] mask_i,
  input wire logic [31:0] cmp_i,
  input wire wpt_res_acc_t acc_i,
  output logic hit_o
);
  logic equal;
  logic core_ok;

  assign equal = (acc_i.id & mask_i) == cmp_i;
  assign core_ok = ctl_i[CTL_CORE_LSB + 32'(acc_i.core)];
  assign hit_o = acc_i.valid && ctl_i[CTL_EN_BIT] && core_ok && (ctl_i[CTL_INV_BIT] ? !equal : equal);
endmodule : wpt_res_cmp

// *** rtl/wpt_top.sv ***
// Data and resource watchpoint block with a classic Wishbone register slave
`timescale 1ns/1ns
module wpt_top
  import wpt_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  // Wishbone classic slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [WPT_ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Memory access port
  input wire logic MEM_VALID_I,
  input wire logic MEM_STORE_I,
  input wire logic [WPT_CORE_W-1:0] MEM_CORE_I,
  input wire logic [31:0] MEM_ADDR_I,
  // Resource access port
  input wire logic RES_VALID_I,
  input wire logic [WPT_CORE_W-1:0] RES_CORE_I,
  input wire logic [31:0] RES_ID_I,
  // Debug interrupt and hit reports
  output logic DBG_IRQ_O,
  output logic [WPT_NUM-1:0] DATA_HIT_O,
  output logic [WPT_NUM-1:0] RES_HIT_O
);
  wpt_state_t st;
  wpt_state_t next_st;
  wpt_mem_acc_t mem_acc;
  wpt_res_acc_t res_acc;
  logic [WPT_NUM-1:0] dw_match;
  logic [WPT_NUM-1:0] rw_match;
  logic [7:0] idx;
  logic [1:0] sub;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [31:0] rd_val;
  logic [31:0] lane_mask;

  // Pack the access ports
  assign mem_acc = '{valid: MEM_VALID_I, store: MEM_STORE_I, core: MEM_CORE_I, addr: MEM_ADDR_I};
  assign res_acc = '{valid: RES_VALID_I, core: RES_CORE_I, id: RES_ID_I};

  // Bus decode: word index and bank slot
  assign idx = WB_ADR_I[WPT_ADR_W-1:2];
  assign sub = idx[1:0];
  assign bus_req = WB_CYC_I && WB_STB_I;
  assign bus_wr = bus_req && WB_WE_I && st.ack; // Write lands at the acked edge
  assign bus_rd = bus_req && !WB_WE_I && st.ack;
  assign lane_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

  // Comparators, one per watchpoint
  genvar g;
  generate
    for (g = 0; g < WPT_NUM; g++) begin : g_wp
      wpt_data_cmp u_data (
        .ctl_i(st.dw_ctl[g]),
        .first_i(st.dw_first[g]),
        .second_i(st.dw_second[g]),
        .acc_i(mem_acc),
        .hit_o(dw_match[g])
      );
      wpt_res_cmp u_res (
        .ctl_i(st.rw_ctl[g]),
        .mask_i(st.rw_mask[g]),
        .cmp_i(st.rw_cmp[g]),
        .acc_i(res_acc),
        .hit_o(rw_match[g])
      );
    end
  endgenerate

  // Register read multiplexer; unmapped words read as zero
  always_comb begin
    rd_val = 32'h00000000;
    if (idx[7:2] == IDX_DW_FIRST[7:2]) begin
      rd_val = st.dw_first[sub];
    end else if (idx[7:2] == IDX_DW_SECOND[7:2]) begin
      rd_val = st.dw_second[sub];
    end else if (idx[7:2] == IDX_DW_CTL[7:2]) begin
      rd_val = st.dw_ctl[sub];
    end else if (idx[7:2] == IDX_RW_MASK[7:2]) begin
      rd_val = st.rw_mask[sub];
    end else if (idx[7:2] == IDX_RW_CMP[7:2]) begin
      rd_val = st.rw_cmp[sub];
    end else if (idx[7:2] == IDX_RW_CTL[7:2]) begin
      rd_val = st.rw_ctl[sub];
    end else if (idx == IDX_CAUSE) begin
      rd_val = st.cause;
    end else if (idx == IDX_CAPTURE) begin
      rd_val = st.capture;
    end else if (idx == IDX_IRQ_STATUS) begin
      rd_val = {{(32 - IRQ_W){1'b0}}, st.irq_status};
    end else if (idx == IDX_IRQ_MASK) begin
      rd_val = {{(32 - IRQ_W){1'b0}}, st.irq_mask};
    end
  end

  // Byte-lane merge of write data into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                        input logic [31:0] lanes, input logic [31:0] wmask);
    logic [31:0] sel;
    sel = lanes & wmask;
    merge = (old & ~sel) | (wdat & sel);
  endfunction : merge

  // Lowest set bit of a hit vector
  function automatic logic [1:0] lowest(input logic [WPT_NUM-1:0] v);
    lowest = 2'h0;
    for (int i = WPT_NUM - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest = 2'(i);
      end
    end
  endfunction : lowest

  // Next-state logic
  always_comb begin
    next_st = st;
    // Ack for one cycle, dropped the cycle after
    next_st.ack = bus_req && !st.ack;
    if (bus_req && !st.ack) begin
      next_st.rdat = rd_val;
    end
    // Software writes
    if (bus_wr) begin
      if (idx[7:2] == IDX_DW_FIRST[7:2]) begin
        next_st.dw_first[sub] = merge(st.dw_first[sub], WB_DAT_I, lane_mask, 32'hFFFFFFFF);
      end else if (idx[7:2] == IDX_DW_SECOND[7:2]) begin
        next_st.dw_second[sub] = merge(st.dw_second[sub], WB_DAT_I, lane_mask, 32'hFFFFFFFF);
      end else if (idx[7:2] == IDX_DW_CTL[7:2]) begin
        next_st.dw_ctl[sub] = merge(st.dw_ctl[sub], WB_DAT_I, lane_mask, DW_CTL_WMASK);
      end else if (idx[7:2] == IDX_RW_MASK[7:2]) begin
        next_st.rw_mask[sub] = merge(st.rw_mask[sub], WB_DAT_I, lane_mask, 32'hFFFFFFFF);
      end else if (idx[7:2] == IDX_RW_CMP[7:2]) begin
        next_st.rw_cmp[sub] = merge(st.rw_cmp[sub], WB_DAT_I, lane_mask, 32'hFFFFFFFF);
      end else if (idx[7:2] == IDX_RW_CTL[7:2]) begin
        next_st.rw_ctl[sub] = merge(st.rw_ctl[sub], WB_DAT_I, lane_mask, RW_CTL_WMASK);
      end else if (idx == IDX_IRQ_MASK) begin
        next_st.irq_mask = IRQ_W'(merge({{(32 - IRQ_W){1'b0}}, st.irq_mask}, WB_DAT_I, lane_mask,
                                        32'h00000003));
      end
    end
    // Reading the status register clears only the bits that the read returned
    if (bus_rd && idx == IDX_IRQ_STATUS) begin
      next_st.irq_status = st.irq_status & ~st.rdat[IRQ_W-1:0]; // A bit set after the data was taken survives
    end
    // Registered hit reports
    next_st.dw_hit = dw_match;
    next_st.rw_hit = rw_match;
    // Hit capture; data takes priority over resource, set wins over read clear
    if (|dw_match) begin
      next_st.cause = 32'(CAUSE_DATA);
      next_st.cause[CAUSE_NUM_LSB +: 2] = lowest(dw_match);
      next_st.cause[CAUSE_CORE_LSB +: WPT_CORE_W] = MEM_CORE_I;
      next_st.capture = MEM_ADDR_I;
      next_st.irq_status[IRQ_DATA_BIT] = 1'b1;
    end else if (|rw_match) begin
      next_st.cause = 32'(CAUSE_RES);
      next_st.cause[CAUSE_NUM_LSB +: 2] = lowest(rw_match);
      next_st.cause[CAUSE_CORE_LSB +: WPT_CORE_W] = RES_CORE_I;
      next_st.capture = RES_ID_I;
    end
    if (|rw_match) begin
      next_st.irq_status[IRQ_RES_BIT] = 1'b1;
    end
  end

  // State register
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      st <= '0;
      for (int i = 0; i < WPT_NUM; i++) begin
        st.dw_ctl[i] <= CTL_RESET;
        st.rw_ctl[i] <= CTL_RESET;
      end
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign WB_ACK_O = st.ack;
  assign WB_DAT_O = st.rdat;
  assign DBG_IRQ_O = |(st.irq_status & st.irq_mask);
  assign DATA_HIT_O = st.dw_hit;
  assign RES_HIT_O = st.rw_hit;
endmodule : wpt_top

// *** sim/wpt_checker.sv ***
// Port checker for the watchpoint block
`timescale 1ns/1ns
module wpt_checker
  import wpt_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [WPT_ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_ACK_O,
  input wire logic MEM_VALID_I,
  input wire logic MEM_STORE_I,
  input wire logic [WPT_CORE_W-1:0] MEM_CORE_I,
  input wire logic RES_VALID_I,
  input wire logic DBG_IRQ_O,
  input wire logic [WPT_NUM-1:0] DATA_HIT_O,
  input wire logic [WPT_NUM-1:0] RES_HIT_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic [31:0] ctl0;
  logic [1:0] im;
  wire wr = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O & (WB_SEL_I == 4'hF);
  // Shadow of watchpoint 0 control and irq mask
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      ctl0 <= 32'h0;
      im <= 2'h0;
    end else if (wr) begin
      if (WB_ADR_I == {IDX_DW_CTL, 2'h0}) ctl0 <= WB_DAT_I;
      if (WB_ADR_I == {IDX_IRQ_MASK, 2'h0}) im <= WB_DAT_I[1:0];
    end
  end
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  AST_ACK_NEXT: assert property (s_req |=> WB_ACK_O) else $error("ack late");
  AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
  AST_DHIT_SRC: assert property (|DATA_HIT_O |-> $past(MEM_VALID_I)) else $error("stray data hit");
  AST_RHIT_SRC: assert property (|RES_HIT_O |-> $past(RES_VALID_I)) else $error("stray res hit");
  AST_EN_GATE: assert property (MEM_VALID_I && !ctl0[0] |=> !DATA_HIT_O[0]) else $error("disabled hit");
  AST_CORE_GATE: assert property (MEM_VALID_I && !ctl0[CTL_CORE_LSB + MEM_CORE_I] |=> !DATA_HIT_O[0])
    else $error("core masked hit");
  AST_LOAD_GATE: assert property (MEM_VALID_I && !MEM_STORE_I && !ctl0[2] |=> !DATA_HIT_O[0])
    else $error("load hit");
  AST_IRQ_HIT: assert property ((|DATA_HIT_O && im[0]) || (|RES_HIT_O && im[1]) |-> DBG_IRQ_O)
    else $error("irq missing");
endmodule : wpt_checker
bind wpt_top wpt_checker u_chk (.*);

// *** sim/wpt_core_model.sv ***
// Core pipeline model issuing memory and resource accesses
`timescale 1ns/1ns
module wpt_core_model
  import wpt_pkg::*;
(
  input wire logic clk_i,
  output wpt_mem_acc_t mem_o,
  output wpt_res_acc_t res_o
);
  wpt_mem_acc_t mq[$];
  wpt_res_acc_t rq[$];
  wpt_mem_acc_t mem_n;
  wpt_res_acc_t res_n;
  initial begin
    mem_o = '0;
    res_o = '0;
    mem_n = '0;
    res_n = '0;
  end
  // Pop mid-cycle so a note pushed at a rising edge never races the pop
  always @(negedge clk_i) begin
    mem_n = mq.size() ? mq.pop_front() : {1'b0, ~mem_o[35:0]};
    res_n = rq.size() ? rq.pop_front() : {1'b0, ~res_o[34:0]};
  end
  // One access a cycle; idle lines toggle
  always @(posedge clk_i) begin
    mem_o <= mem_n;
    res_o <= res_n;
  end
endmodule : wpt_core_model

// *** sim/tb_top.sv ***
// Self-checking bench for the watchpoint block
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top
  import wpt_pkg::*;
;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, irq, v_d = 0;
  logic [9:0] adr = 10'h0;
  logic [3:0] sel = 4'hF, dh, rh;
  logic [31:0] dat = 32'h0, seed = 32'hEDBD, rdat, id, lid, e;
  logic [7:0] eh;
  logic [31:0] qr[$];
  logic [7:0] qh[$];
  int bad_count = 0, n_checks = 0;
  wpt_mem_acc_t m;
  wpt_res_acc_t r;
  always #50 clk = ~clk;
  wpt_top dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .MEM_VALID_I(m.valid), .MEM_STORE_I(m.store), .MEM_CORE_I(m.core), .MEM_ADDR_I(m.addr),
    .RES_VALID_I(r.valid), .RES_CORE_I(r.core), .RES_ID_I(r.id),
    .DBG_IRQ_O(irq), .DATA_HIT_O(dh), .RES_HIT_O(rh));
  wpt_core_model pm (.clk_i(clk), .mem_o(m), .res_o(r));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic wb(input logic w, input logic [7:0] i, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'h0};
    dat <= d;
    // Wait for ack as long as it takes; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic rd(input logic [7:0] i, input logic [31:0] x);
    repeat (3) @(posedge clk);
    qr.push_back(x);
    wb(1'b0, i, 32'h0);
  endtask : rd
  task automatic acc(input logic s, input logic st, input logic [2:0] c, input logic [31:0] a, input logic [7:0] h);
    if (s) pm.rq.push_back({1'b1, c, a});
    else pm.mq.push_back({1'b1, st, c, a});
    qh.push_back(h);
    @(posedge clk);
  endtask : acc
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // Pair observed results with the oldest note
  always @(posedge clk) begin
    if (v_d) begin
      eh = qh.pop_front();
      `CHK("hits", eh, {dh, rh})
    end
    if (ack === 1'b1 && !we) begin
      e = qr.pop_front();
      `CHK("rdata", e, rdat)
    end
    v_d <= m.valid | r.valid;
  end
  initial begin
    #2000000;
    bad_count++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(IDX_DW_CTL + 8'h3, 32'h0);
    rd(IDX_RW_CTL + 8'h3, 32'h0);
    rd(8'hFF, 32'h0);
    // Byte lane write touches only its lane
    sel <= 4'h2;
    wb(1'b1, IDX_DW_FIRST + 8'h1, 32'hAABBCCDD);
    sel <= 4'hF;
    rd(IDX_DW_FIRST + 8'h1, 32'h0000CC00);
    // Reserved control bits stay zero
    wb(1'b1, IDX_RW_CTL + 8'h2, 32'hFFFFFFFF);
    rd(IDX_RW_CTL + 8'h2, 32'h00FF0003);
    wb(1'b1, IDX_IRQ_MASK, 32'h1);
    wb(1'b1, IDX_DW_FIRST, 32'h100);
    wb(1'b1, IDX_DW_SECOND, 32'h200);
    wb(1'b1, IDX_DW_CTL, 32'h00040001);
    acc(0, 1, 2, 32'h100, 8'h10);
    acc(0, 1, 2, 32'h200, 8'h10);
    acc(0, 1, 2, 32'h201, 8'h00);
    acc(0, 0, 2, 32'h150, 8'h00);
    acc(0, 1, 3, 32'h150, 8'h00);
    acc(0, 1, 2, 32'hFFFFFF80, 8'h00);
    rd(IDX_CAUSE, 32'h204);
    rd(IDX_CAPTURE, 32'h200);
    `CHK("irq", 1'b1, irq)
    rd(IDX_IRQ_STATUS, 32'h1);
    `CHK("irq", 1'b0, irq)
    wb(1'b1, IDX_RW_MASK + 8'h1, 32'hFF00);
    wb(1'b1, IDX_RW_CMP + 8'h1, 32'h1200);
    for (int v = 0; v < 2; v++) begin
      wb(1'b1, IDX_RW_CTL + 8'h1, 32'h00FF0001 | (v << 1));
      for (int k = 0; k < 6; k++) begin
        id = xs();
        if (k[0]) id[15:8] = 8'h12;
        if (((id & 32'hFF00) == 32'h1200) ^ v[0]) lid = id;
        acc(1, 0, id[2:0], id, {6'h0, ((id & 32'hFF00) == 32'h1200) ^ v[0], 1'b0});
      end
    end
    rd(IDX_CAUSE, {14'h0, 2'h1, 5'h0, lid[2:0], 5'h0, 3'h5});
    rd(IDX_CAPTURE, lid);
    `CHK("irq", 1'b0, irq)
    // Unmasking the resource bit raises the interrupt
    wb(1'b1, IDX_IRQ_MASK, 32'h3);
    `CHK("irq", 1'b1, irq)
    rd(IDX_IRQ_STATUS, 32'h2);
    `CHK("irq", 1'b0, irq)
    wb(1'b1, IDX_DW_CTL, 32'h00040005);
    acc(0, 0, 2, 32'h150, 8'h10);
    wb(1'b1, IDX_DW_CTL, 32'h00040007);
    acc(0, 1, 2, 32'h100, 8'h00);
    acc(0, 1, 2, 32'h200, 8'h00);
    acc(0, 0, 2, 32'h201, 8'h10);
    acc(0, 1, 2, 32'hFF, 8'h10);
    wb(1'b1, IDX_DW_CTL, 32'h00040006);
    acc(0, 1, 2, 32'h300, 8'h00);
    wb(1'b1, IDX_DW_SECOND + 8'h2, 32'hFFFFFFFF);
    wb(1'b1, IDX_DW_CTL + 8'h2, 32'h00FF0001);
    wb(1'b1, IDX_DW_CTL, 32'h00FF0001);
    acc(0, 1, 5, 32'h180, 8'h50);
    rd(IDX_CAUSE, 32'h504);
    rd(IDX_IRQ_STATUS, 32'h1);
    close_out();
  end
endmodule : tb_top
